// ==== rtl/rssi_pwm_indicator.sv ====
// signal-strength indicator: pwm on the shared config pin
// Notes on behaviour
// - period is 40 equal steps of 0.208 ms, 8.32 ms in total.
// - high time ranges from zero to 95 percent of the period.
// - signal at or below sensitivity gives zero duty.
// - 10, 20, 30 dB above sensitivity give 47.5, 62.5, 77.5 %.
// - hold time 0..0x7F times 100 ms; zero disables; zero default.
// - nonzero hold shows strength for hold time, then output low.
// - output low from power-up until a packet arrives.
// - hold value 0xFF keeps the output permanently active.
// - shared pin is an input and sampled at power-up for command mode.
// - afterwards, with nonzero hold, pin becomes an output driven low.
// - with nonzero hold, pin stays input for hold-value ms after power-up.
// - hold time is command code 0x22; a read returns one byte.
// - last packet level kept in 0x06..0x36, higher is stronger.
`timescale 1ns/1ps
module rssi_pwm_indicator
  import rssi_pwm_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYCLES,
  parameter int UNIT_CYC = HOLD_UNIT_CYC,
  parameter int MSEC_CYC = MS_CYCLES
)(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       pkt_valid,
  input  wire logic [7:0] pkt_level,
  input  wire logic [7:0] hold_time_boot,
  input  wire logic       cmd_wr,
  input  wire logic       cmd_rd,
  input  wire logic [7:0] cmd_code,
  input  wire logic [7:0] cmd_wdata,
  output logic            rd_valid,
  output logic      [7:0] rd_data,
  output logic      [7:0] last_packet_signal_level,
  output logic            cmd_mode,
  input  wire logic       config_pin_i,
  output logic            config_pin_o,
  output logic            config_pin_oe
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [5:0]    duty_steps;
  logic          pin_sync1_ff;
  logic          pin_sync2_ff;
  logic [2:0]    strap_cnt_ff;
  logic          boot_done_ff;
  logic [7:0]    signal_indicator_hold_time_ff;
  logic [23:0]   step_cnt_ff;
  logic [5:0]    step_idx_ff;
  logic          active_ff;
  logic [6:0]    hold_left_ff;
  logic [23:0]   unit_cnt_ff;
  logic [23:0]   ms_cnt_ff;
  logic [7:0]    ms_elapsed_ff;
  pin_phase_type phase_ff;
  pin_phase_type nxt_phase;
  logic          hit_cmd;
  logic          wr_ok;
  logic          step_end;
  logic          unit_end;

  assign hit_cmd  = (cmd_code == CMD_HOLD_TIME);
  assign wr_ok    = (cmd_wdata <= HOLD_RANGE_MAX) ||
                    (cmd_wdata == HOLD_FOREVER);
  assign step_end = (step_cnt_ff == 24'(STEP_CYC - 1));
  assign unit_end = (unit_cnt_ff == 24'(UNIT_CYC - 1));

  level_to_duty u_map (
    .clk                      (clk),
    .rstn                     (rstn),
    .ce                       (ce),
    .pkt_valid                (pkt_valid),
    .pkt_level                (pkt_level),
    .last_packet_signal_level (last_packet_signal_level),
    .duty_steps               (duty_steps)
  );

  // ---------------------------------------------------------------
  // pin synchroniser and power-up strap
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_sync1_ff <= 1'b1;
      pin_sync2_ff <= 1'b1;
    end else if (ce) begin
      pin_sync1_ff <= config_pin_i;
      pin_sync2_ff <= pin_sync1_ff;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_cnt_ff <= 3'h0;
      cmd_mode     <= 1'b0;
    end else if (ce && phase_ff == PIN_STRAP) begin
      strap_cnt_ff <= strap_cnt_ff + 3'h1;
      if (strap_cnt_ff == 3'(STRAP_CYCLES - 1)) begin
        cmd_mode <= ~pin_sync2_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin direction phases
  // ---------------------------------------------------------------
  always_comb begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      PIN_STRAP: begin
        if (strap_cnt_ff == 3'(STRAP_CYCLES - 1)) begin
          nxt_phase = PIN_INPUT;
        end
      end
      PIN_INPUT: begin
        if (signal_indicator_hold_time_ff != 8'h00 &&
            ms_elapsed_ff >= signal_indicator_hold_time_ff) begin
          nxt_phase = PIN_DRIVE;
        end
      end
      PIN_DRIVE: begin
        // a larger setting written later reopens the input window
        if (signal_indicator_hold_time_ff == 8'h00) begin
          nxt_phase = PIN_INPUT;
        end else if (ms_elapsed_ff < signal_indicator_hold_time_ff) begin
          nxt_phase = PIN_INPUT;
        end
      end
      default: nxt_phase = PIN_STRAP;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_ff      <= PIN_STRAP;
      config_pin_oe <= 1'b0;
    end else if (ce) begin
      phase_ff      <= nxt_phase;
      config_pin_oe <= (nxt_phase == PIN_DRIVE);
    end
  end

  // milliseconds since power-up, saturating
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ms_cnt_ff     <= 24'h000000;
      ms_elapsed_ff <= 8'h00;
    end else if (ce && ms_elapsed_ff != MS_SATURATE) begin
      if (ms_cnt_ff == 24'(MSEC_CYC - 1)) begin
        ms_cnt_ff     <= 24'h000000;
        ms_elapsed_ff <= ms_elapsed_ff + 8'h01;
      end else begin
        ms_cnt_ff <= ms_cnt_ff + 24'h000001;
      end
    end
  end

  // ---------------------------------------------------------------
  // hold-time setting and command port
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boot_done_ff                  <= 1'b0;
      signal_indicator_hold_time_ff <= HOLD_RESET;
    end else if (ce) begin
      boot_done_ff <= 1'b1;
      if (!boot_done_ff) begin
        if ((hold_time_boot <= HOLD_RANGE_MAX) ||
            (hold_time_boot == HOLD_FOREVER)) begin
          signal_indicator_hold_time_ff <= hold_time_boot;
        end
      end else if (cmd_wr && hit_cmd && wr_ok) begin
        signal_indicator_hold_time_ff <= cmd_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
    end else if (ce) begin
      rd_valid <= cmd_rd && hit_cmd;
      if (cmd_rd && hit_cmd) begin
        rd_data <= signal_indicator_hold_time_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // activity hold timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_ff    <= 1'b0;
      hold_left_ff <= 7'h00;
      unit_cnt_ff  <= 24'h000000;
    end else if (ce) begin
      if (signal_indicator_hold_time_ff == 8'h00) begin
        active_ff <= 1'b0;
      end else if (pkt_valid) begin
        active_ff    <= 1'b1;
        hold_left_ff <= signal_indicator_hold_time_ff[6:0];
        unit_cnt_ff  <= 24'h000000;
      end else if (signal_indicator_hold_time_ff != HOLD_FOREVER &&
                   active_ff) begin
        if (unit_end) begin
          unit_cnt_ff  <= 24'h000000;
          hold_left_ff <= hold_left_ff - 7'h01;
          if (hold_left_ff <= 7'h01) begin
            active_ff <= 1'b0;
          end
        end else begin
          unit_cnt_ff <= unit_cnt_ff + 24'h000001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // pwm waveform
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_cnt_ff <= 24'h000000;
      step_idx_ff <= 6'h00;
    end else if (ce) begin
      if (step_end) begin
        step_cnt_ff <= 24'h000000;
        if (step_idx_ff == 6'(PWM_STEPS - 1)) begin
          step_idx_ff <= 6'h00;
        end else begin
          step_idx_ff <= step_idx_ff + 6'h01;
        end
      end else begin
        step_cnt_ff <= step_cnt_ff + 24'h000001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      config_pin_o <= 1'b0;
    end else if (ce) begin
      config_pin_o <= active_ff && (step_idx_ff < duty_steps);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_STEP_WRAP: assert property (
    (ce && step_end && step_idx_ff == 6'(PWM_STEPS - 1)) |=>
      step_idx_ff == 6'h00 && step_cnt_ff == 24'h000000)
    else $error("step index did not wrap after last step");
  AST_IDLE_LOW: assert property (
    (ce && !active_ff) |=> !config_pin_o)
    else $error("output high while inactive");
  AST_PKT_WAKES: assert property (
    (ce && pkt_valid && boot_done_ff &&
     signal_indicator_hold_time_ff != 8'h00) |=> active_ff)
    else $error("packet did not activate indicator");
  AST_ZERO_NO_DRIVE: assert property (
    (signal_indicator_hold_time_ff == 8'h00 && phase_ff != PIN_DRIVE)
      |-> !config_pin_oe)
    else $error("pin driven with zero hold");
  AST_FOREVER: assert property (
    (ce && active_ff && !cmd_wr &&
     signal_indicator_hold_time_ff == HOLD_FOREVER) |=> active_ff)
    else $error("permanent mode dropped activity");
  AST_RD_BYTE: assert property (
    (ce && cmd_rd && hit_cmd) |=>
      rd_valid && rd_data == $past(signal_indicator_hold_time_ff))
    else $error("read did not return hold setting");
  AST_BAD_WRITE: assert property (
    (ce && boot_done_ff && cmd_wr && hit_cmd && !wr_ok) |=>
      $stable(signal_indicator_hold_time_ff))
    else $error("out-of-range hold setting accepted");
  AST_OE_WAIT: assert property (
    config_pin_oe |-> ms_elapsed_ff >= signal_indicator_hold_time_ff ||
      $past(signal_indicator_hold_time_ff) != signal_indicator_hold_time_ff)
    else $error("pin driven before hold ms elapsed");
  AST_STRAP_INPUT: assert property (
    (phase_ff == PIN_STRAP) |-> !config_pin_oe)
    else $error("pin driven during power-up sampling");

  COV_PULSE: cover property (active_ff && config_pin_o);
  COV_TIMEOUT: cover property (active_ff ##1 !active_ff);
  COV_DRIVE: cover property (phase_ff == PIN_DRIVE);
  COV_READ: cover property (rd_valid);
endmodule

// ==== rtl/rssi_pwm_pkg.sv ====
// constants and types shared by the signal-strength indicator files
package rssi_pwm_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int PERIOD_TIME_NS  = 8320000;
  localparam int PWM_STEPS       = 40;
  localparam int PERIOD_CYCLES   = PERIOD_TIME_NS / CLK_PERIOD_NS;
  localparam int STEP_CYCLES     = PERIOD_CYCLES / PWM_STEPS;
  localparam int HOLD_UNIT_NS    = 100000000;
  localparam int HOLD_UNIT_CYC   = HOLD_UNIT_NS / CLK_PERIOD_NS;
  localparam int MS_TIME_NS      = 1000000;
  localparam int MS_CYCLES       = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int STRAP_CYCLES    = 4;
  // ---------------------------------------------------------------
  // duty mapping
  // ---------------------------------------------------------------
  localparam logic [5:0] DUTY_MAX_STEPS = 6'h26;
  localparam logic [5:0] DUTY_BASE      = 6'h0D;
  localparam logic [7:0] LEVEL_MIN      = 8'h06;
  localparam logic [7:0] LEVEL_MAX      = 8'h36;
  localparam logic [7:0] LEVEL_SENS     = 8'h06;
  // ---------------------------------------------------------------
  // command port
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_HOLD_TIME  = 8'h22;
  localparam logic [7:0] HOLD_RANGE_MAX = 8'h7F;
  localparam logic [7:0] HOLD_FOREVER   = 8'hFF;
  localparam logic [7:0] HOLD_RESET     = 8'h00;
  localparam logic [7:0] MS_SATURATE    = 8'hFF;

  typedef enum logic [1:0] {
    PIN_STRAP = 2'b00,
    PIN_INPUT = 2'b01,
    PIN_DRIVE = 2'b10
  } pin_phase_type;
endpackage

// ==== rtl/level_to_duty.sv ====
// last packet signal level store and duty step mapping
`timescale 1ns/1ps
module level_to_duty
  import rssi_pwm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       pkt_valid,
  input  wire logic [7:0] pkt_level,
  output logic      [7:0] last_packet_signal_level,
  output logic      [5:0] duty_steps
);
  // ---------------------------------------------------------------
  // mapping
  // ---------------------------------------------------------------
  // 1.5 % per dB above sensitivity, 2.5 % per step: 13 + 0.6 * dB
  function automatic logic [5:0] duty_of(input logic [7:0] lvl);
    logic [7:0]  db;
    logic [11:0] raw;
    db  = 8'h00;
    raw = 12'h000;
    if (lvl <= LEVEL_SENS) begin
      duty_of = 6'h00;
    end else begin
      db  = lvl - LEVEL_SENS;
      raw = 12'(DUTY_BASE) + 12'((12'(db) * 12'h006) / 12'h00A);
      if (raw > 12'(DUTY_MAX_STEPS)) begin
        duty_of = DUTY_MAX_STEPS;
      end else begin
        duty_of = raw[5:0];
      end
    end
  endfunction

  function automatic logic [7:0] clamp_level(input logic [7:0] lvl);
    if (lvl < LEVEL_MIN) begin
      clamp_level = LEVEL_MIN;
    end else if (lvl > LEVEL_MAX) begin
      clamp_level = LEVEL_MAX;
    end else begin
      clamp_level = lvl;
    end
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_packet_signal_level <= LEVEL_MIN;
      duty_steps               <= 6'h00;
    end else if (ce && pkt_valid) begin
      last_packet_signal_level <= clamp_level(pkt_level);
      duty_steps               <= duty_of(clamp_level(pkt_level));
    end
  end

  AST_DUTY_LIMIT: assert property (@(posedge clk) disable iff (!rstn)
    duty_steps <= DUTY_MAX_STEPS)
    else $error("duty above 95 percent");
  AST_WEAK_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    (ce && pkt_valid && pkt_level <= LEVEL_SENS) |=> duty_steps == 6'h00)
    else $error("weak packet gave nonzero duty");
endmodule

// ==== verification/pin_host_model.sv ====
// host side of the shared config pin: strap level and pin resolution
`timescale 1ns/1ps
module pin_host_model (
  input  wire logic clk,
  input  wire logic strap_low,
  input  wire logic config_pin_o,
  input  wire logic config_pin_oe,
  output logic      pin_level,
  output logic      rise_seen
);
  logic last_ff;
  // pull-up keeps the pin high unless the host straps it low; while config_pin_oe is set the pin follows config_pin_o
  assign pin_level = config_pin_oe ? config_pin_o : !strap_low;
  always_ff @(posedge clk) begin
    last_ff <= pin_level;
  end
  assign rise_seen = pin_level && !last_ff;
endmodule

// ==== verification/rssi_pwm_indicator_tb_top.sv ====
// self-checking bench for the signal-strength indicator
`timescale 1ns/1ps
module rssi_pwm_indicator_tb_top;
  import rssi_pwm_pkg::*;
  logic       clk, rstn, ce, pkt_valid, cmd_wr, cmd_rd, strap_low;
  logic [7:0] pkt_level, hold_time_boot, cmd_code, cmd_wdata;
  logic       rd_valid, cmd_mode, pin_o, pin_oe, pin_level, rise_seen;
  logic [7:0] rd_data, level;
  int         n_mismatch, checks_done;

  initial clk = 1'b0;
  always #25 clk = !clk;

  rssi_pwm_indicator #(.STEP_CYC(4), .UNIT_CYC(20), .MSEC_CYC(3)) uut (
    .clk(clk), .rstn(rstn), .ce(ce), .pkt_valid(pkt_valid),
    .pkt_level(pkt_level), .hold_time_boot(hold_time_boot),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
    .last_packet_signal_level(level), .cmd_mode(cmd_mode),
    .config_pin_i(pin_level), .config_pin_o(pin_o),
    .config_pin_oe(pin_oe)
  );
  pin_host_model host (
    .clk(clk), .strap_low(strap_low), .config_pin_o(pin_o),
    .config_pin_oe(pin_oe), .pin_level(pin_level),
    .rise_seen(rise_seen)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic do_reset(input logic [7:0] boot);
    @(posedge clk);
    rstn <= 1'b0;
    hold_time_boot <= boot;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
  endtask

  task automatic cmd(input logic w, input logic [7:0] code,
                     input logic [7:0] d);
    @(posedge clk);
    cmd_wr <= w;
    cmd_rd <= !w;
    cmd_code <= code;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] code, input logic ok,
                    input logic [7:0] exp);
    cmd(1'b0, code, 8'h00);
    #1;
    check(rd_valid, ok, "read answer");
    if (ok)
      check(rd_data, exp, "read byte");
    @(posedge clk);
    #1;
    check(rd_valid, 1'b0, "answer one cycle");
  endtask

  task automatic pkt(input logic [7:0] lvl);
    @(posedge clk);
    pkt_valid <= 1'b1;
    pkt_level <= lvl;
    @(posedge clk);
    pkt_valid <= 1'b0;
  endtask

  task automatic measure(input int n, output int hi, output int ri);
    hi = 0;
    ri = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      hi += int'(pin_level === 1'b1);
      ri += int'(rise_seen === 1'b1);
    end
  endtask

  function automatic int exp_steps(input int l);
    int s;
    s = 13 + 6 * (l - 6) / 10;
    if (l <= 6)
      return 0;
    return (s > 38) ? 38 : s;
  endfunction

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    int hi, ri;
    do_reset(8'h00);
    #1;
    check(pin_oe, 1'b0, "pin released after reset");
    check(level, 8'h06, "level reset");
    repeat (6) @(posedge clk);
    #1;
    check(cmd_mode, 1'b1, "strap low gives command mode");
    rd(CMD_HOLD_TIME, 1'b1, 8'h00);
    check(pin_oe, 1'b0, "hold zero leaves pin input");
    $display("test reset done");
  endtask

  task automatic t_cmd;
    int hi, ri;
    cmd(1'b1, CMD_HOLD_TIME, 8'h05);
    rd(CMD_HOLD_TIME, 1'b1, 8'h05);
    cmd(1'b1, CMD_HOLD_TIME, 8'h80);
    rd(CMD_HOLD_TIME, 1'b1, 8'h05);
    rd(8'h23, 1'b0, 8'h00);
    cmd(1'b1, CMD_HOLD_TIME, 8'h7F);
    rd(CMD_HOLD_TIME, 1'b1, 8'h7F);
    cmd(1'b1, CMD_HOLD_TIME, 8'hFF);
    rd(CMD_HOLD_TIME, 1'b1, 8'hFF);
    check(pin_oe, 1'b0, "input for 255 ms");
    repeat (760) @(posedge clk);
    #1;
    check(pin_oe, 1'b1, "nonzero hold drives pin");
    measure(40, hi, ri);
    check(16'(hi), 16'd0, "low before first packet");
    $display("test command done");
  endtask

  task automatic t_duty;
    logic [7:0] lv [8] = '{8'h02, 8'h06, 8'h07, 8'h10, 8'h1A, 8'h24,
                          8'h36, 8'h40};
    int hi, ri, s, cl;
    foreach (lv[i]) begin
      cl = (lv[i] < 8'h06) ? 6 : (lv[i] > 8'h36) ? 54 : int'(lv[i]);
      s = exp_steps(cl);
      pkt(lv[i]);
      #1;
      check(level, 8'(cl), "level clamp");
      repeat (3) @(posedge clk);
      measure(320, hi, ri);
      check(16'(hi), 16'(8 * s), "high time");
      check(16'(ri), (s > 0) ? 16'd2 : 16'd0, "period");
    end
    repeat (6000) @(posedge clk);
    measure(160, hi, ri);
    check(16'(hi), 16'd152, "forever hold at 95 pct");
    $display("test duty done");
  endtask

  task automatic t_freeze;
    logic p;
    @(posedge clk);
    ce <= 1'b0;
    pkt(8'h07);
    #1;
    p = pin_o;
    check(level, 8'h36, "frozen level");
    repeat (20) @(posedge clk);
    #1;
    check(pin_o, p, "frozen pwm");
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    #1;
    check(level, 8'h36, "packet ignored while frozen");
    $display("test freeze done");
  endtask

  task automatic t_hold;
    int hi, ri;
    cmd(1'b1, CMD_HOLD_TIME, 8'h02);
    pkt(8'h36);
    repeat (3) @(posedge clk);
    measure(30, hi, ri);
    check(16'(hi > 0), 16'd1, "active within hold");
    repeat (12) @(posedge clk);
    measure(160, hi, ri);
    check(16'(hi), 16'd0, "low after hold");
    check(pin_oe, 1'b1, "still driven after hold");
    pkt(8'h36);
    repeat (3) @(posedge clk);
    measure(30, hi, ri);
    check(16'(hi > 0), 16'd1, "new packet restarts");
    cmd(1'b1, CMD_HOLD_TIME, 8'h00);
    pkt(8'h36);
    repeat (5) @(posedge clk);
    #1;
    check(pin_oe, 1'b0, "zero disables drive");
    check(pin_o, 1'b0, "zero disables pwm");
    $display("test hold done");
  endtask

  task automatic t_boot;
    strap_low <= 1'b0;
    do_reset(8'h0A);
    repeat (25) @(posedge clk);
    #1;
    check(pin_oe, 1'b0, "input for hold ms");
    check(cmd_mode, 1'b0, "strap high no command mode");
    repeat (15) @(posedge clk);
    #1;
    check(pin_oe, 1'b1, "driven after hold ms");
    check(pin_o, 1'b0, "driven low");
    rd(CMD_HOLD_TIME, 1'b1, 8'h0A);
    $display("test boot done");
  endtask

  initial begin
    #(50 * 100000);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    {rstn, pkt_valid, cmd_wr, cmd_rd} = '0;
    {pkt_level, hold_time_boot, cmd_code, cmd_wdata} = '0;
    ce = 1'b1;
    strap_low = 1'b1;
    t_reset();
    t_cmd();
    t_duty();
    t_freeze();
    t_hold();
    t_boot();
    wrap_up();
  end
endmodule
